//--- hw/sub_params.svh
/*
  Constants of the subtract unit: register offsets, opcode patterns, field
  positions and reset values.
  Assumes inclusion by bare name from sub_unit and the testbench.
*/
`ifndef SUB_PARAMS_SVH
`define SUB_PARAMS_SVH

`define SUB_OFS_INSTR 8'h00
`define SUB_OFS_ACC 8'h04
`define SUB_OFS_STATUS 8'h08
`define SUB_OFS_FADDR 8'h0C
`define SUB_OFS_FDATA 8'h10

`define SUB_OP_LIT_HI 13
`define SUB_OP_LIT_LO 9
`define SUB_OP_LIT 5'h1E
`define SUB_OP_FILE_HI 13
`define SUB_OP_FILE_LO 8
`define SUB_OP_FILE 6'h02
`define SUB_DEST_BIT 7
`define SUB_LIT_HI 7
`define SUB_FADDR_HI 6

`define SUB_ST_C 0
`define SUB_ST_NIB 1
`define SUB_ST_Z 2

`define SUB_ACC_RST 8'h00
`define SUB_FLAG_RST 1'b0
`define SUB_FADDR_RST 7'h00

`endif

//--- hw/sub_pkg.sv
/*
  Types of the subtract unit: control states, register selects and the
  result of one subtraction.
  Assumes the params header is on the include path.
*/
`default_nettype none
package sub_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_DONE = 2'b11
  } sub_state_t;

  typedef enum logic [2:0] {
    REG_INSTR,
    REG_ACC,
    REG_STATUS,
    REG_FADDR,
    REG_FDATA,
    REG_NONE
  } sub_reg_t;

  typedef struct packed {
    logic [7:0] result;
    logic c;
    logic nib;
    logic z;
  } sub_result_t;
endpackage : sub_pkg
`default_nettype wire

//--- hw/sub_file_mem.sv
/*
  File register store, 128 x 8, one write port and one read port whose
  data come out of a register.
  Assumes one clock, active-low asynchronous reset and a clock enable.
*/
`default_nettype none
module sub_file_mem (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic rd_en,
  input wire logic [6:0] raddr,
  output logic [7:0] rdata,
  input wire logic wr_en,
  input wire logic [6:0] waddr,
  input wire logic [7:0] wdata
);
  logic [7:0] mem [0:127];

  // Storage array
  always_ff @(posedge pclk) begin
    if (ce && wr_en) begin
      mem[waddr] <= wdata;
    end
  end

  // Registered read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata <= 8'h00;
    end else if (ce && rd_en) begin
      rdata <= mem[raddr];
    end
  end
endmodule : sub_file_mem
`default_nettype wire

//--- hw/sub_unit.sv
/*
  Subtract execution unit: immediate-minus-accumulator and
  file-minus-accumulator with carry, nibble carry and zero flags, reached
  over an APB slave.
  Assumes an APB master on pclk, inputs synchronous to pclk.
*/
`include "sub_params.svh"
`default_nettype none
module sub_unit (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [7:0] acc,
  output logic carry_flag,
  output logic nibble_carry_flag,
  output logic zero_flag
);
  function automatic sub_pkg::sub_reg_t reg_decode(input logic [7:0] addr);
    sub_pkg::sub_reg_t r;
    if (addr == `SUB_OFS_INSTR) begin
      r = sub_pkg::REG_INSTR;
    end else if (addr == `SUB_OFS_ACC) begin
      r = sub_pkg::REG_ACC;
    end else if (addr == `SUB_OFS_STATUS) begin
      r = sub_pkg::REG_STATUS;
    end else if (addr == `SUB_OFS_FADDR) begin
      r = sub_pkg::REG_FADDR;
    end else if (addr == `SUB_OFS_FDATA) begin
      r = sub_pkg::REG_FDATA;
    end else begin
      r = sub_pkg::REG_NONE;
    end
    return r;
  endfunction : reg_decode

  // Two's-complement subtract m - a with inverted-borrow flags
  function automatic sub_pkg::sub_result_t sub_calc(input logic [7:0] m,
                                                    input logic [7:0] a);
    sub_pkg::sub_result_t r;
    logic [8:0] full;
    logic [4:0] low;
    full = {1'b0, m} + {1'b0, ~a} + 9'h001;
    low = {1'b0, m[3:0]} + {1'b0, ~a[3:0]} + 5'h01;
    r.result = full[7:0];
    r.c = full[8];
    r.nib = low[4];
    r.z = (full[7:0] == 8'h00);
    return r;
  endfunction : sub_calc

  sub_pkg::sub_state_t state;
  sub_pkg::sub_reg_t sel_q;
  logic wr_q;
  logic [31:0] wdata_q;
  logic [6:0] file_addr;
  logic [7:0] mem_rdata;
  logic mem_rd;
  logic [6:0] mem_raddr;
  logic mem_wr;
  logic [6:0] mem_waddr;
  logic [7:0] mem_wdata;
  logic access;
  logic op_lit;
  logic op_file;
  logic dest_file;
  logic do_exec;
  logic [7:0] minuend;
  sub_pkg::sub_result_t res;

  assign access = psel && penable && (state == sub_pkg::ST_IDLE);
  assign op_lit = (wdata_q[`SUB_OP_LIT_HI:`SUB_OP_LIT_LO] == `SUB_OP_LIT);
  assign op_file = (wdata_q[`SUB_OP_FILE_HI:`SUB_OP_FILE_LO] == `SUB_OP_FILE);
  assign dest_file = wdata_q[`SUB_DEST_BIT];
  assign do_exec = ce && (state == sub_pkg::ST_EXEC) && wr_q &&
                   (sel_q == sub_pkg::REG_INSTR) && (op_lit || op_file);
  assign minuend = op_lit ? wdata_q[`SUB_LIT_HI:0] : mem_rdata;
  assign res = sub_calc(minuend, acc);

  // File operand fetched in the cycle the request is taken
  assign mem_rd = access;
  assign mem_raddr = (reg_decode(paddr) == sub_pkg::REG_INSTR) ?
                     pwdata[`SUB_FADDR_HI:0] : file_addr;

  always_comb begin
    mem_wr = 1'b0;
    mem_waddr = file_addr;
    mem_wdata = wdata_q[7:0];
    if (do_exec && op_file && dest_file) begin
      mem_wr = 1'b1;
      mem_waddr = wdata_q[`SUB_FADDR_HI:0];
      mem_wdata = res.result;
    end else if (ce && state == sub_pkg::ST_EXEC && wr_q &&
                 sel_q == sub_pkg::REG_FDATA) begin
      mem_wr = 1'b1;
    end
  end

  sub_file_mem u_mem (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .rd_en(mem_rd),
    .raddr(mem_raddr),
    .rdata(mem_rdata),
    .wr_en(mem_wr),
    .waddr(mem_waddr),
    .wdata(mem_wdata)
  );

  // Request capture and sequencing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= sub_pkg::ST_IDLE;
      sel_q <= sub_pkg::REG_NONE;
      wr_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
    end else if (ce) begin
      case (state)
        sub_pkg::ST_IDLE: begin
          if (access) begin
            sel_q <= reg_decode(paddr);
            wr_q <= pwrite;
            wdata_q <= pwdata;
            state <= sub_pkg::ST_EXEC;
          end
        end
        sub_pkg::ST_EXEC: begin
          state <= sub_pkg::ST_DONE;
        end
        default: begin
          state <= sub_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // APB answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (ce) begin
      pready <= (state == sub_pkg::ST_EXEC);
      if (state == sub_pkg::ST_EXEC) begin
        pslverr <= (sel_q == sub_pkg::REG_NONE) ||
                   (wr_q && sel_q == sub_pkg::REG_INSTR && !op_lit && !op_file);
        prdata <= 32'h0000_0000;
        if (!wr_q) begin
          if (sel_q == sub_pkg::REG_ACC) begin
            prdata <= {24'h00_0000, acc};
          end else if (sel_q == sub_pkg::REG_STATUS) begin
            prdata <= {29'h0000_0000, zero_flag, nibble_carry_flag, carry_flag};
          end else if (sel_q == sub_pkg::REG_FADDR) begin
            prdata <= {25'h000_0000, file_addr};
          end else if (sel_q == sub_pkg::REG_FDATA) begin
            prdata <= {24'h00_0000, mem_rdata};
          end
        end
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // Accumulator
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc <= `SUB_ACC_RST;
    end else if (ce && state == sub_pkg::ST_EXEC && wr_q) begin
      if (do_exec && (op_lit || !dest_file)) begin
        acc <= res.result;
      end else if (sel_q == sub_pkg::REG_ACC) begin
        acc <= wdata_q[7:0];
      end
    end
  end

  // Status flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      carry_flag <= `SUB_FLAG_RST;
      nibble_carry_flag <= `SUB_FLAG_RST;
      zero_flag <= `SUB_FLAG_RST;
    end else if (do_exec) begin
      carry_flag <= res.c;
      nibble_carry_flag <= res.nib;
      zero_flag <= res.z;
    end
  end

  // File address pointer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      file_addr <= `SUB_FADDR_RST;
    end else if (ce && state == sub_pkg::ST_EXEC && wr_q &&
                 sel_q == sub_pkg::REG_FADDR) begin
      file_addr <= wdata_q[`SUB_FADDR_HI:0];
    end
  end

  // Independent reference values for checking
  logic [7:0] chk_diff;
  logic chk_gt;
  logic chk_eq;
  logic chk_lt;
  logic chk_lowok;
  assign chk_diff = 8'(minuend - acc);
  assign chk_gt = minuend > acc;
  assign chk_eq = minuend == acc;
  assign chk_lt = acc > minuend;
  assign chk_lowok = minuend[3:0] >= acc[3:0];

  sequence s_exec_lit;
    do_exec && op_lit;
  endsequence

  sequence s_exec_file(logic d);
    do_exec && op_file && dest_file == d;
  endsequence

  a_lit_acc_write: assert property (@(posedge pclk) disable iff (!presetn)
    s_exec_lit |=> acc == $past(chk_diff))
    else $error("immediate subtract result wrong");

  a_file_to_acc: assert property (@(posedge pclk) disable iff (!presetn)
    s_exec_file(1'b0) |-> !mem_wr ##1 acc == $past(chk_diff))
    else $error("file subtract to accumulator wrong");

  a_file_to_reg: assert property (@(posedge pclk) disable iff (!presetn)
    s_exec_file(1'b1) |-> mem_wr && mem_wdata == chk_diff ##1 $stable(acc))
    else $error("file subtract to register wrong");

  a_carry_greater: assert property (@(posedge pclk) disable iff (!presetn)
    do_exec && chk_gt |=> carry_flag)
    else $error("carry not set when minuend larger");

  a_carry_equal: assert property (@(posedge pclk) disable iff (!presetn)
    do_exec && chk_eq |=> carry_flag && zero_flag)
    else $error("carry not set on equal operands");

  a_carry_less: assert property (@(posedge pclk) disable iff (!presetn)
    do_exec && chk_lt |=> !carry_flag)
    else $error("carry not cleared on borrow");

  a_zero_nibble: assert property (@(posedge pclk) disable iff (!presetn)
    do_exec |=> zero_flag == ($past(chk_diff) == 8'h00) &&
                nibble_carry_flag == $past(chk_lowok))
    else $error("zero or nibble carry flag wrong");

  a_exec_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
    do_exec |=> pready ##1 !pready)
    else $error("subtract did not finish in one cycle");
endmodule : sub_unit
`default_nettype wire

//--- verif/siu_host.sv
/*
  Partner model: the core side that hands instructions and file data to the
  subtract unit over APB, as a master with a blocking transfer task.
  Assumes pclk and a design answering with pready.
*/
`default_nettype none
module sub_host (
  input wire logic pclk,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end

  // Setup, then access held until pready is seen high; address and data lines invert afterwards
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : sub_host
`default_nettype wire

//--- verif/subtract_instruction_unit_tb.sv
/*
  Self-checking bench of the subtract unit: both subtract forms, flags,
  destination select and refused accesses.
  Assumes the design files and sub_host are compiled first.
*/
`include "sub_params.svh"
`default_nettype none
module subtract_instruction_unit_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, err;
  logic carry_flag, nibble_carry_flag, zero_flag;
  logic [7:0] paddr, acc;
  logic [31:0] pwdata, prdata, q;
  int fails, cmp_count, cycles;

  sub_unit u_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .acc(acc),
    .carry_flag(carry_flag), .nibble_carry_flag(nibble_carry_flag),
    .zero_flag(zero_flag));
  sub_host u_host (.pclk(pclk), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      test_done();
    end
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d, q, err);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    u_host.xfer(1'b0, a, 32'h0000_0000, q, err);
  endtask : rd

  // One subtraction with minuend m and accumulator w, then all results
  task automatic do_sub(input logic [13:0] op, input logic [7:0] m, input logic [7:0] w);
    logic file_op;
    logic to_file;
    logic [7:0] res;
    logic [2:0] st;
    file_op = (op[13] == 1'b0);
    to_file = file_op && op[7];
    res = m - w;
    st = {res == 8'h00, m[3:0] >= w[3:0], m >= w};
    wr(`SUB_OFS_ACC, {24'h00_0000, w});
    if (file_op) begin
      wr(`SUB_OFS_FADDR, {25'h000_0000, op[6:0]});
      wr(`SUB_OFS_FDATA, {24'h00_0000, m});
    end
    wr(`SUB_OFS_INSTR, {18'h0_0000, op});
    chk("instr_err", 32'h0000_0000, {31'h0000_0000, err});
    chk("acc", {24'h00_0000, to_file ? w : res}, {24'h00_0000, acc});
    chk("flags", {29'h0, st}, {29'h0, zero_flag, nibble_carry_flag, carry_flag});
    rd(`SUB_OFS_STATUS);
    chk("status", {29'h0, st}, {29'h0, q[2:0]});
    if (file_op) begin
      rd(`SUB_OFS_FDATA);
      chk("file", {24'h00_0000, to_file ? res : m}, {24'h00_0000, q[7:0]});
    end
  endtask : do_sub

  task automatic test_reset;
    rd(`SUB_OFS_ACC);
    chk("acc_rst", 32'h0000_0000, q);
    chk("flags_rst", 32'h0000_0000, {29'h0, zero_flag, nibble_carry_flag, carry_flag});
  endtask : test_reset

  task automatic test_literal;
    logic [15:0] tbl [7] = '{16'h0201, 16'h0202, 16'h0203, 16'h1001, 16'h00FF,
                             16'hFF00, 16'h5A5A};
    for (int i = 0; i < 7; i++) begin
      do_sub({5'h1E, i[0], tbl[i][15:8]}, tbl[i][15:8], tbl[i][7:0]);
    end
  endtask : test_literal

  task automatic test_file;
    logic [15:0] tbl [3] = '{16'h0302, 16'h0202, 16'h0102};
    for (int d = 0; d < 2; d++) begin
      for (int i = 0; i < 3; i++) begin
        do_sub({6'h02, d[0], i[0] ? 7'h7F : 7'h00}, tbl[i][15:8], tbl[i][7:0]);
      end
    end
  endtask : test_file

  // Clock enable held low while an execute is pending
  task automatic test_freeze;
    wr(`SUB_OFS_ACC, 32'h0000_0001);
    fork
      wr(`SUB_OFS_INSTR, 32'h0000_3C05);
      begin
        repeat (3) @(posedge pclk);
        ce <= 1'b0;
        repeat (4) @(posedge pclk);
        chk("acc_frozen", 32'h0000_0001, {24'h00_0000, acc});
        chk("ready_frozen", 32'h0000_0000, {31'h0000_0000, pready});
        ce <= 1'b1;
      end
    join
    chk("acc_thawed", 32'h0000_0004, {24'h00_0000, acc});
    chk("flags_thawed", 32'h0000_0003, {29'h0, zero_flag, nibble_carry_flag, carry_flag});
  endtask : test_freeze

  task automatic test_refuse;
    do_sub({5'h1E, 1'b0, 8'h33}, 8'h33, 8'h33);
    wr(`SUB_OFS_ACC, 32'h0000_0033);
    wr(`SUB_OFS_STATUS, 32'h0000_0000);
    chk("status_wr_err", 32'h0000_0000, {31'h0000_0000, err});
    rd(`SUB_OFS_STATUS);
    chk("flags_kept", 32'h0000_0007, q);
    rd(`SUB_OFS_INSTR);
    chk("instr_rd", 32'h0000_0000, q);
    wr(`SUB_OFS_FADDR, 32'h0000_005A);
    rd(`SUB_OFS_FADDR);
    chk("faddr_rd", 32'h0000_005A, q);
    wr(8'h14, 32'h0000_0001);
    chk("unmapped_wr_err", 32'h0000_0001, {31'h0000_0000, err});
    wr(`SUB_OFS_INSTR, 32'h0000_3A00);
    chk("bad_op_err", 32'h0000_0001, {31'h0000_0000, err});
    rd(8'h14);
    chk("unmapped_rd_err", 32'h0000_0001, {31'h0000_0000, err});
    rd(`SUB_OFS_ACC);
    chk("acc_kept", 32'h0000_0033, q);
  endtask : test_refuse

  // Reset pulse in mid-run clears accumulator and flags again
  task automatic test_midreset;
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    test_reset();
  endtask : test_midreset

  initial begin
    fails = 0;
    cmp_count = 0;
    cycles = 0;
    ce = 1'b1;
    presetn = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    test_reset();
    test_literal();
    test_file();
    test_freeze();
    test_refuse();
    test_midreset();
    test_done();
  end
endmodule : subtract_instruction_unit_tb
`default_nettype wire
